/* rtl/ja_bit_fifo.sv */
// One-bit-wide attenuator FIFO, 32 or 128 entries deep.
// Assumes the controller flushes it whenever the depth changes.
`timescale 1ns/1ns
`default_nettype none
module ja_bit_fifo
  import t1_ja_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  ja_fifo_if.fifo port_if
);
  logic mem [0:127];
  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic [LVL_W-1:0] level_reg;
  logic rd_bit_reg;
  wire [LVL_W-1:0] cap = fifo_cap(port_if.depth_short); // see R3
  wire [PTR_W-1:0] ptr_mask = PTR_W'(cap - 8'd1);
  wire do_wr = port_if.wr_en && (level_reg < cap);
  wire do_rd = port_if.rd_en && (level_reg != 8'd0);
  wire [PTR_W-1:0] wptr_next = (wptr_reg + 7'd1) & ptr_mask;
  wire [PTR_W-1:0] rptr_next = (rptr_reg + 7'd1) & ptr_mask;

  always_ff @(posedge clock_in) begin
    if (do_wr) begin
      mem[wptr_reg] <= port_if.wr_bit;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || port_if.flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      level_reg <= '0;
      rd_bit_reg <= 1'b0;
    end else begin
      if (do_wr) begin
        wptr_reg <= wptr_next;
      end
      if (do_rd) begin
        rptr_reg <= rptr_next;
        rd_bit_reg <= mem[rptr_reg];
      end
      level_reg <= LVL_W'(level_reg + {7'd0, do_wr} - {7'd0, do_rd});
    end
  end

  assign port_if.rd_bit = rd_bit_reg;
  assign port_if.level = level_reg;
endmodule
`default_nettype wire

/* rtl/ja_fifo_if.sv */
// Carrier between the attenuator control and its bit FIFO.
// Both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface ja_fifo_if;
  logic wr_en;
  logic wr_bit;
  logic rd_en;
  logic rd_bit;
  logic flush;
  logic depth_short;
  logic [7:0] level;
  modport fifo (input wr_en, wr_bit, rd_en, flush, depth_short, output rd_bit, level);
  modport ctrl (output wr_en, wr_bit, rd_en, flush, depth_short, input rd_bit, level);
endinterface
`default_nettype wire

/* rtl/t1_ja_pkg.sv */
// Constants, field layout and types of the T1 build-out and jitter
// attenuator control block. Assumes an APB slave with 8-bit byte addresses.
package t1_ja_pkg;
  // Register byte addresses
  localparam logic [7:0] LINE_CTRL_ADDR = 8'h7C;
  localparam logic [7:0] RX_INFO3_ADDR = 8'h80;
  localparam logic [7:0] IMASK_ADDR = 8'h84;
  // Line interface control fields
  localparam int BOS_LSB = 5;
  localparam int EGL_BIT = 4;
  localparam int PATH_BIT = 3;
  localparam int DEPTH_BIT = 2;
  localparam int DIS_BIT = 1;
  localparam int TPD_BIT = 0;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  // Receive information register 3 and interrupt mask
  localparam int LIMIT_BIT = 5;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STAT_USED = 8'h20;
  // FIFO sizes and jitter limits in unit intervals
  localparam int PTR_W = 7;
  localparam int LVL_W = 8;
  localparam logic [LVL_W-1:0] DEPTH_LONG = 8'h80;
  localparam logic [LVL_W-1:0] DEPTH_SHORT = 8'h20;
  localparam logic [LVL_W-1:0] LIMIT_LONG_UI = 8'd120;
  localparam logic [LVL_W-1:0] LIMIT_SHORT_UI = 8'd28;
  // Internal clock synthesis from the system clock
  localparam int SYS_CLK_KHZ = 250000;
  localparam int INT_CLK_KHZ = 24704;
  // Must hold the modulus plus one step without wrapping
  localparam int ACC_W = 19;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(INT_CLK_KHZ);
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(SYS_CLK_KHZ);
  // Read clock divisors
  localparam logic [4:0] DIV_NOM = 5'd16;
  localparam logic [4:0] DIV_FAST = 5'd15;
  localparam logic [4:0] DIV_SLOW = 5'd17;
  // Build-out codes
  localparam logic [2:0] BOS_LAST_SHORT = 3'h4;

  typedef enum logic [1:0] {
    JA_FILL = 2'b01,
    JA_RUN = 2'b10
  } ja_state_t;

  typedef enum logic [1:0] {
    ATT_0DB = 2'h0,
    ATT_7P5DB = 2'h1,
    ATT_15DB = 2'h2,
    ATT_22P5DB = 2'h3
  } csu_atten_t;

  function automatic logic [LVL_W-1:0] fifo_cap(input logic short_sel);
    fifo_cap = short_sel ? DEPTH_SHORT : DEPTH_LONG;
  endfunction

  function automatic logic [LVL_W-1:0] half_window(input logic short_sel);
    half_window = (short_sel ? LIMIT_SHORT_UI : LIMIT_LONG_UI) >> 1;
  endfunction
endpackage

/* rtl/t1_jitter_attenuator_lbo_ctrl.sv */
// Build-out decode and jitter attenuator control of a T1 line interface.
// Assumes line clocks and data arrive asynchronously and are far slower
// than clock_in; registers are reached over APB.
// Contract
// R1: Build-out codes 000 to 100 select short-haul ranges in 133 ft steps up to 655 ft.
// R2: Build-out codes 101, 110 and 111 select CSU attenuation of -7.5, -15 and -22.5 dB.
// R3: The attenuator FIFO is 32 or 128 bits deep as the depth-select bit chooses.
// R4: Software picks 128 bits where wander is large and 32 bits where delay must be small.
// R5: The path-select bit puts the attenuator in the receive or the transmit path.
// R6: With the disable bit set the attenuator is bypassed entirely.
// R7: The smoothed read clock is derived from the receive or transmit line clock per path.
// R8: In the transmit path a gapped or bursty transmit line clock still gives a smooth clock.
// R9: Jitter above 120 UI (128 deep) or 28 UI (32 deep) is a limit condition.
// R10: The read clock is 24.704 MHz divided by 16, or by 15 or 17 in the limit condition.
// R11: While dividing by 15 or 17 the limit-trip flag, bit 5 of status register 3, is set.
// R12: The system supplies a 1.544 MHz reference within 50 ppm on the master clock; the block has no such input and derives its 24.704 MHz tick from clock_in.
// R13: When the fill level is back within range the divisor returns to 16.
`timescale 1ns/1ns
`default_nettype none
module t1_jitter_attenuator_lbo_ctrl
  import t1_ja_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_line_clock_in,
  input wire logic rx_line_data_in,
  input wire logic tx_line_clock_in,
  input wire logic tx_line_data_in,
  output logic rx_clock_out,
  output logic rx_data_out,
  output logic tx_clock_out,
  output logic tx_data_out,
  output logic lbo_short_haul_out,
  output logic [2:0] lbo_range_out,
  output logic [1:0] lbo_csu_atten_out,
  output logic eq_gain_limit_out,
  output logic tx_power_down_out,
  output logic irq_out
);
  // Input synchronisers: bit 0 rx clock, 1 rx data, 2 tx clock, 3 tx data
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] prev_reg;
  // Registers
  logic [7:0] line_ctrl_reg;
  logic [7:0] line_ctrl_next;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [2:0] cfg_prev_reg;
  // Read clock synthesis
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [4:0] div_cnt_reg;
  logic [4:0] div_cnt_next;
  logic [4:0] div_reg;
  logic [4:0] div_next;
  logic ja_clk_reg;
  ja_state_t state_reg;
  ja_state_t state_next;
  // Outputs
  logic rx_clk_reg;
  logic rx_dat_reg;
  logic tx_clk_reg;
  logic tx_dat_reg;
  logic lbo_short_reg;
  logic [2:0] lbo_range_reg;
  csu_atten_t lbo_att_reg;
  csu_atten_t lbo_att_next;
  logic lbo_short_next;
  logic [2:0] lbo_range_next;

  ja_fifo_if fifo_if ();

  ja_bit_fifo u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .port_if(fifo_if)
  );

  // APB decode
  wire apb_access = psel_in && penable_in;
  wire apb_write = apb_access && pwrite_in;
  wire hit_line_ctrl = (paddr_in == LINE_CTRL_ADDR);
  wire hit_stat = (paddr_in == RX_INFO3_ADDR);
  wire hit_mask = (paddr_in == IMASK_ADDR);
  wire addr_hit = hit_line_ctrl || hit_stat || hit_mask;
  wire wr_line_ctrl = apb_write && hit_line_ctrl;
  wire wr_stat = apb_write && hit_stat;
  wire wr_mask = apb_write && hit_mask;
  wire [7:0] rd_mux = hit_line_ctrl ? line_ctrl_reg :
                      hit_stat ? stat_reg :
                      hit_mask ? mask_reg : 8'h00;

  // Control fields
  wire [2:0] build_out_select = line_ctrl_reg[BOS_LSB +: 3];
  wire ja_path_select = line_ctrl_reg[PATH_BIT];
  wire ja_depth_select = line_ctrl_reg[DEPTH_BIT];
  wire ja_disable = line_ctrl_reg[DIS_BIT];
  wire [2:0] cfg_now = {ja_path_select, ja_depth_select, ja_disable};
  wire cfg_change = (cfg_now != cfg_prev_reg);
  wire ja_in_rx = !ja_disable && !ja_path_select; // see R5
  wire ja_in_tx = !ja_disable && ja_path_select; // see R5

  // Line edges are found only on the second synchroniser stage
  wire [3:0] rise = sync_reg & ~prev_reg;
  wire src_rise = ja_path_select ? rise[2] : rise[0]; // see R7
  wire src_bit = ja_path_select ? sync_reg[3] : sync_reg[1];

  // Fill-level window around the centre of the chosen depth
  wire [LVL_W-1:0] cap = fifo_cap(ja_depth_select); // see R3
  wire [LVL_W-1:0] centre = cap >> 1;
  wire [LVL_W-1:0] win = half_window(ja_depth_select);
  wire [LVL_W-1:0] lim_hi = LVL_W'(centre + win); // see R9
  wire [LVL_W-1:0] lim_lo = LVL_W'(centre - win); // see R9
  wire over_hi = fifo_if.level > lim_hi;
  wire under_lo = fifo_if.level < lim_lo;

  // Internal 24.704 MHz tick by phase accumulation on clock_in
  wire [ACC_W-1:0] acc_sum = ACC_W'(acc_reg + ACC_STEP);
  wire int_tick = acc_sum >= ACC_MOD;
  wire period_end = int_tick && (div_cnt_reg == 5'(div_reg - 5'd1));
  wire read_strobe = period_end && (state_reg == JA_RUN) && !ja_disable;
  wire limit_event = period_end && !ja_disable && (div_reg != DIV_NOM); // see R11
  wire ja_clk_next = !ja_disable && (div_cnt_reg < (div_reg >> 1));

  assign fifo_if.wr_en = !ja_disable && src_rise && !cfg_change; // see R8
  assign fifo_if.wr_bit = src_bit;
  assign fifo_if.rd_en = read_strobe;
  assign fifo_if.flush = cfg_change || ja_disable; // see R6
  assign fifo_if.depth_short = ja_depth_select;

  // Line outputs: attenuated path or the synchronised line signal
  wire rx_clk_next = ja_in_rx ? ja_clk_reg : sync_reg[0]; // see R6
  wire rx_dat_next = ja_in_rx ? fifo_if.rd_bit : sync_reg[1]; // see R5
  wire tx_clk_next = ja_in_tx ? ja_clk_reg : sync_reg[2]; // see R6
  wire tx_dat_next = ja_in_tx ? fifo_if.rd_bit : sync_reg[3]; // see R5

  // Register next values; a new limit event beats a clear in the same cycle
  always_comb begin
    line_ctrl_next = wr_line_ctrl ? pwdata_in[7:0] : line_ctrl_reg;
    mask_next = wr_mask ? (pwdata_in[7:0] & STAT_USED) : mask_reg;
    stat_next = stat_reg & ~(wr_stat ? pwdata_in[7:0] : 8'h00);
    if (limit_event) begin
      stat_next[LIMIT_BIT] = 1'b1; // see R11
    end
  end

  // Divisor chosen once per read period, so each period is whole
  always_comb begin
    acc_next = int_tick ? ACC_W'(acc_sum - ACC_MOD) : acc_sum;
    div_cnt_next = div_cnt_reg;
    div_next = div_reg;
    if (int_tick) begin
      div_cnt_next = period_end ? 5'd0 : 5'(div_cnt_reg + 5'd1);
    end
    if (period_end) begin
      if (state_reg != JA_RUN) begin
        div_next = DIV_NOM;
      end else if (over_hi) begin
        div_next = DIV_FAST; // see R10
      end else if (under_lo) begin
        div_next = DIV_SLOW; // see R10
      end else begin
        div_next = DIV_NOM; // see R13
      end
    end
  end

  // Reads start only once the FIFO has filled to its centre
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      JA_FILL: begin
        if (!fifo_if.flush && fifo_if.level >= centre) begin
          state_next = JA_RUN;
        end
      end
      JA_RUN: begin
        if (fifo_if.flush || fifo_if.level == 8'd0) begin
          state_next = JA_FILL;
        end
      end
      default: begin
        state_next = JA_FILL;
      end
    endcase
  end

  // Build-out decode; every code is legal, so the case has no default
  always_comb begin
    unique case (build_out_select)
      3'h0: begin
        lbo_short_next = 1'b1; // see R1
        lbo_range_next = 3'h0;
        lbo_att_next = ATT_0DB;
      end
      3'h1: begin
        lbo_short_next = 1'b1; // see R1
        lbo_range_next = 3'h1;
        lbo_att_next = ATT_0DB;
      end
      3'h2: begin
        lbo_short_next = 1'b1; // see R1
        lbo_range_next = 3'h2;
        lbo_att_next = ATT_0DB;
      end
      3'h3: begin
        lbo_short_next = 1'b1; // see R1
        lbo_range_next = 3'h3;
        lbo_att_next = ATT_0DB;
      end
      3'h4: begin
        lbo_short_next = 1'b1; // see R1
        lbo_range_next = 3'h4;
        lbo_att_next = ATT_0DB;
      end
      3'h5: begin
        lbo_short_next = 1'b0;
        lbo_range_next = 3'h0;
        lbo_att_next = ATT_7P5DB; // see R2
      end
      3'h6: begin
        lbo_short_next = 1'b0;
        lbo_range_next = 3'h0;
        lbo_att_next = ATT_15DB; // see R2
      end
      3'h7: begin
        lbo_short_next = 1'b0;
        lbo_range_next = 3'h0;
        lbo_att_next = ATT_22P5DB; // see R2
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_reg <= 4'h0;
      sync_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      meta_reg <= {tx_line_data_in, tx_line_clock_in, rx_line_data_in, rx_line_clock_in};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      line_ctrl_reg <= LINE_CTRL_RESET;
      stat_reg <= STAT_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      line_ctrl_reg <= line_ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_prev_reg <= 3'h0;
    end else begin
      cfg_prev_reg <= cfg_now;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      acc_reg <= '0;
      div_cnt_reg <= 5'd0;
      div_reg <= DIV_NOM;
    end else begin
      acc_reg <= acc_next;
      div_cnt_reg <= div_cnt_next;
      div_reg <= div_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ja_clk_reg <= 1'b0;
      state_reg <= JA_FILL;
    end else begin
      ja_clk_reg <= ja_clk_next;
      state_reg <= state_next;
    end
  end

  // Bypassed paths pass the synchronised line signals with no buffering
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_clk_reg <= 1'b0;
      rx_dat_reg <= 1'b0;
    end else begin
      rx_clk_reg <= rx_clk_next;
      rx_dat_reg <= rx_dat_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_clk_reg <= 1'b0;
      tx_dat_reg <= 1'b0;
    end else begin
      tx_clk_reg <= tx_clk_next;
      tx_dat_reg <= tx_dat_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lbo_short_reg <= 1'b1;
      lbo_range_reg <= 3'h0;
      lbo_att_reg <= ATT_0DB;
    end else begin
      lbo_short_reg <= lbo_short_next; // see R1
      lbo_range_reg <= lbo_range_next; // see R1
      lbo_att_reg <= lbo_att_next; // see R2
    end
  end

  assign prdata_out = {24'h000000, rd_mux};
  assign pready_out = 1'b1;
  assign pslverr_out = apb_access && !addr_hit;
  assign rx_clock_out = rx_clk_reg;
  assign rx_data_out = rx_dat_reg;
  assign tx_clock_out = tx_clk_reg;
  assign tx_data_out = tx_dat_reg;
  assign lbo_short_haul_out = lbo_short_reg;
  assign lbo_range_out = lbo_range_reg;
  assign lbo_csu_atten_out = lbo_att_reg;
  assign eq_gain_limit_out = line_ctrl_reg[EGL_BIT];
  assign tx_power_down_out = line_ctrl_reg[TPD_BIT];
  assign irq_out = |(stat_reg & mask_reg);
endmodule
`default_nettype wire

/* test/t1_jitter_attenuator_lbo_ctrl_bench.sv */
// Self-checking bench of the build-out and attenuator control block.
// Assumes two line source models feed the receive and transmit lines.
`timescale 1ns/1ns
`default_nettype none
module t1_jitter_attenuator_lbo_ctrl_bench;
  import t1_ja_pkg::*;
  logic clock_in, rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, e, tx_gap;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic rx_line_clock_in, rx_line_data_in, tx_line_clock_in, tx_line_data_in;
  logic rx_clock_out, rx_data_out, tx_clock_out, tx_data_out, lbo_short_haul_out;
  logic eq_gain_limit_out, tx_power_down_out, irq_out;
  logic [2:0] lbo_range_out;
  logic [1:0] lbo_csu_atten_out;
  logic [7:0] addrs [3] = '{LINE_CTRL_ADDR, RX_INFO3_ADDR, IMASK_ADDR};
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int p;
  t1_jitter_attenuator_lbo_ctrl dut (.clock_in, .rst_in, .paddr_in, .psel_in, .penable_in,
    .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .rx_line_clock_in,
    .rx_line_data_in, .tx_line_clock_in, .tx_line_data_in, .rx_clock_out, .rx_data_out,
    .tx_clock_out, .tx_data_out, .lbo_short_haul_out, .lbo_range_out, .lbo_csu_atten_out,
    .eq_gain_limit_out, .tx_power_down_out, .irq_out);
  t1_line_source rx_src (.gap_in(1'b0), .line_clock_out(rx_line_clock_in),
    .line_data_out(rx_line_data_in));
  t1_line_source tx_src (.gap_in(tx_gap), .line_clock_out(tx_line_clock_in),
    .line_data_out(tx_line_data_in));
  initial begin
    clock_in = 1'b0;
    // The exact system clock stands in for the reference clock
    forever #2 clock_in = ~clock_in;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The whole run needs about 13000 cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic period(input logic tx, output int p);
    time t0;
    if (tx) @(posedge tx_clock_out);
    else @(posedge rx_clock_out);
    t0 = $time;
    if (tx) @(posedge tx_clock_out);
    else @(posedge rx_clock_out);
    p = int'(($time - t0) / 4);
  endtask
  initial begin
    rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    tx_gap = 1'b0;
    tick(20);
    rst_in <= 1'b0;
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b1, 8'h88, 32'hFF);
    check("unmapped error", e, 1'b1);
    apb(1'b1, IMASK_ADDR, 32'hFF);
    apb(1'b0, IMASK_ADDR, 32'h0);
    check("mask", rd, STAT_USED);
    apb(1'b1, LINE_CTRL_ADDR, 32'hF1);
    apb(1'b0, LINE_CTRL_ADDR, 32'h0);
    check("control", rd, 32'hF1);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, LINE_CTRL_ADDR, 32'(c) << 5);
      tick(3);
      check("short haul", lbo_short_haul_out, c <= 4);
      check("range", lbo_range_out, c <= 4 ? c : 0);
      check("csu atten", lbo_csu_atten_out, c > 4 ? c - 4 : 0);
    end
    $display("test build out done");
    apb(1'b1, LINE_CTRL_ADDR, 32'h02);
    tick(20);
    // Both line models run in step while the transmit line has no gaps
    repeat (4) begin
      @(posedge rx_line_clock_in);
      tick(10);
      check("bypass data", rx_data_out, rx_line_data_in);
      check("bypass clock", rx_clock_out, 1'b1);
      check("bypass tx data", tx_data_out, tx_line_data_in);
      check("bypass tx clock", tx_clock_out, 1'b1);
    end
    $display("test bypass done");
    // Short depth, as a delay-sensitive user would pick
    apb(1'b1, LINE_CTRL_ADDR, 32'h04);
    tick(6000);
    period(1'b0, p);
    check("rx smooth period", p >= 150 && p <= 173, 1'b1);
    apb(1'b0, RX_INFO3_ADDR, 32'h0);
    check("limit trip", rd, STAT_USED);
    check("irq raised", irq_out, 1'b1);
    apb(1'b1, IMASK_ADDR, 32'h0);
    // The mask write lands at the access edge; look one cycle later
    tick(1);
    check("irq masked", irq_out, 1'b0);
    apb(1'b1, LINE_CTRL_ADDR, 32'h02);
    tick(200);
    apb(1'b1, RX_INFO3_ADDR, 32'h20);
    apb(1'b0, RX_INFO3_ADDR, 32'h0);
    check("trip cleared", rd, 32'h0);
    apb(1'b1, IMASK_ADDR, 32'h20);
    $display("test receive path done");
    tx_gap <= 1'b1;
    apb(1'b1, LINE_CTRL_ADDR, 32'h08);
    tick(6000);
    period(1'b1, p);
    check("tx smooth period", p >= 150 && p <= 173, 1'b1);
    period(1'b0, p);
    check("rx direct period", p >= 31 && p <= 32, 1'b1);
    $display("test transmit path done");
    conclude();
  end
endmodule
`default_nettype wire

/* test/t1_jitter_attenuator_lbo_ctrl_props.sv */
// Port checks of the build-out and attenuator control block.
// Assumes zero-wait APB and registered build-out outputs.
`timescale 1ns/1ns
`default_nettype none
module t1_ja_props
  import t1_ja_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic lbo_short_haul_out,
  input wire logic [2:0] lbo_range_out,
  input wire logic [1:0] lbo_csu_atten_out,
  input wire logic eq_gain_limit_out,
  input wire logic tx_power_down_out,
  input wire logic irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic acc, mapped, wr_ctl;
  logic [7:0] val_reg;
  assign acc = psel_in && penable_in;
  assign mapped = paddr_in inside {LINE_CTRL_ADDR, RX_INFO3_ADDR, IMASK_ADDR};
  assign wr_ctl = acc && pwrite_in && paddr_in == LINE_CTRL_ADDR;
  // Last control word, so the decode checks need no local variables
  always_ff @(posedge clock_in) begin
    if (wr_ctl) begin
      val_reg <= pwdata_in[7:0];
    end
  end
  chk_ready_access: assert property (acc |-> pready_out)
    else $error("pready low in access");
  chk_unmapped_refused: assert property (acc && !mapped |-> pslverr_out && prdata_out == 32'h0)
    else $error("unmapped access not refused");
  chk_mapped_clean: assert property (acc && mapped |-> !pslverr_out && prdata_out[31:8] == 24'h0)
    else $error("mapped access refused");
  chk_haul_atten_pair: assert property (lbo_short_haul_out == (lbo_csu_atten_out == 2'h0))
    else $error("haul and atten disagree");
  chk_csu_range_zero: assert property (!lbo_short_haul_out |-> lbo_range_out == 3'h0)
    else $error("range set for csu code");
  chk_range_decode: assert property (wr_ctl ##1 !wr_ctl |=>
    lbo_range_out == (val_reg[7:5] <= 3'h4 ? val_reg[7:5] : 3'h0)) else $error("range wrong");
  chk_csu_decode: assert property (wr_ctl ##1 !wr_ctl |=>
    lbo_csu_atten_out == (val_reg[7:5] > 3'h4 ? 2'(val_reg[7:5] - 3'h4) : 2'h0))
    else $error("atten wrong");
  chk_ctrl_bits: assert property (wr_ctl |=>
    eq_gain_limit_out == val_reg[4] && tx_power_down_out == val_reg[0]) else $error("ctrl bits");
  chk_irq_masked: assert property (acc && pwrite_in && paddr_in == IMASK_ADDR
    && !pwdata_in[LIMIT_BIT] |=> !irq_out) else $error("irq high while masked");
endmodule
bind t1_jitter_attenuator_lbo_ctrl t1_ja_props props (.clock_in, .rst_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .lbo_short_haul_out, .lbo_range_out, .lbo_csu_atten_out, .eq_gain_limit_out,
  .tx_power_down_out, .irq_out);
`default_nettype wire

/* test/t1_line_source.sv */
// Model of a T1 line: a 125 ns line clock with data changing on its fall.
// Assumes nothing of the block; a gap request drops every fourth pulse.
`timescale 1ns/1ns
`default_nettype none
module t1_line_source (
  input wire logic gap_in,
  output logic line_clock_out,
  output logic line_data_out
);
  logic [7:0] lfsr_reg = 8'hA5;
  int n = 0;
  initial begin
    line_clock_out = 1'b0;
    line_data_out = 1'b0;
    // Odd start offset keeps the line unrelated in phase to the system clock
    #7;
    forever begin
      n++;
      line_clock_out = !(gap_in && n % 4 == 0);
      #63;
      line_clock_out = 1'b0;
      lfsr_reg = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      line_data_out = lfsr_reg[0];
      #62;
    end
  end
endmodule
`default_nettype wire
